// [wwr_defs.svh]
// timing and reset constants for the wake/watchdog/reset logic
`ifndef WWR_DEFS_SVH
`define WWR_DEFS_SVH
`define WWR_CLK_NS 100
`define WWR_RESP_NS 2000
`define WWR_RESP_CYC ((`WWR_RESP_NS / `WWR_CLK_NS) < 1 ? 1 : (`WWR_RESP_NS / `WWR_CLK_NS))
`define WWR_PERIOD_UNITS 8
`define WWR_RSTDLY_UNITS 1
`define WWR_ROUSE_UNITS 4
`define WWR_UNIT_DEF 16'h61a8
`define WWR_UNIT_W 16
`define WWR_CNT_W 20
`define WWR_SYNC_RST 3'h0
`endif

// [wwr_pkg.sv]
// types for the wake/watchdog/reset logic
package wwr_pkg;
  typedef enum logic [1:0] {WWR_RESET, WWR_DELAY, WWR_HIGH, WWR_LOW} wwr_state_t;
  typedef struct packed {
    logic rst_n;
    logic wake;
  } wwr_out_t;
endpackage

// [wwr_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`include "wwr_defs.svh"
module wwr_sync (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic d_in, // async input
  output logic q_out // filtered level
);
  logic [2:0] sync;
  // shift chain; stage 0 feeds stage 1 only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync <= `WWR_SYNC_RST;
    end else begin
      sync <= {sync[1:0], d_in};
    end
  end
  // change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= 1'b0;
    end else if (sync[1] == sync[2]) begin
      q_out <= sync[2];
    end
  end
endmodule // wwr_sync

// [wwr_top.sv]
// wake square wave, watchdog edge check and reset generator
`timescale 1ns/1ps
`include "wwr_defs.svh"
module wwr_top
  import wwr_pkg::*;
(
  input wire logic REF_CLK_IN, // 10 MHz clock
  input wire logic NRST_IN, // async reset, active low
  input wire logic POWER_GOOD_IN, // output within 6% of nominal
  input wire logic WATCHDOG_INPUT_IN, // watchdog pin from processor
  input wire logic [`WWR_UNIT_W-1:0] UNIT_IN, // time-base unit in cycles
  output logic WAKE_OUT, // rouse square wave
  output logic RESET_N_OUT // reset to processor, active low
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic pg_level;
  logic wd_level;
  logic wd_prev;
  logic wd_fall;
  logic [`WWR_CNT_W-1:0] cnt;
  logic [`WWR_CNT_W-1:0] half;
  logic [`WWR_CNT_W-1:0] rdly;
  logic [`WWR_CNT_W-1:0] wdly;
  logic seen;
  wwr_state_t state;
  wwr_out_t outs;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // pins come from outside the clock domain
  wwr_sync u_pg (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n),
    .d_in(POWER_GOOD_IN),
    .q_out(pg_level)
  );
  wwr_sync u_wd (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n),
    .d_in(WATCHDOG_INPUT_IN),
    .q_out(wd_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // falling edge detect on filtered watchdog level
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wd_prev <= 1'b0;
    end else begin
      wd_prev <= wd_level;
    end
  end
  assign wd_fall = wd_prev && !wd_level;

  assign half = `WWR_CNT_W'(UNIT_IN) * `WWR_CNT_W'(`WWR_PERIOD_UNITS / 2);
  assign rdly = `WWR_CNT_W'(UNIT_IN) * `WWR_CNT_W'(`WWR_RSTDLY_UNITS);
  assign wdly = `WWR_CNT_W'(UNIT_IN) * `WWR_CNT_W'(`WWR_ROUSE_UNITS);

  // phase end test shared by every timed state and by the checks
  function automatic logic reached(input logic [`WWR_CNT_W-1:0] count,
    input logic [`WWR_CNT_W-1:0] limit);
    return (count + 1'b1) >= limit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer: reset, release delay, wake high half, wake low half
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state <= WWR_RESET;
      cnt <= '0;
      seen <= 1'b0;
    end else if (!pg_level) begin
      state <= WWR_RESET;
      cnt <= '0;
      seen <= 1'b0;
    end else begin
      unique case (state)
        WWR_RESET: begin
          if (reached(cnt, rdly)) begin
            state <= WWR_DELAY;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        WWR_DELAY: begin
          if (reached(cnt, wdly)) begin
            state <= WWR_HIGH;
            cnt <= '0;
            seen <= 1'b0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        WWR_HIGH, WWR_LOW: begin
          if (wd_fall) begin
            seen <= 1'b1;
          end
          if (state == WWR_HIGH && reached(cnt, half)) begin
            state <= WWR_LOW;
            cnt <= '0;
          end else if (state == WWR_LOW && reached(cnt, half)) begin
            cnt <= '0;
            if (seen || wd_fall) begin
              state <= WWR_HIGH;
              seen <= 1'b0;
            end else begin
              state <= WWR_RESET;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs; a fall this cycle drops wake next edge, well under 2 us
  always_comb begin
    outs.rst_n = (state != WWR_RESET) && pg_level;
    // wake low after edge or in reset
    outs.wake = (state == WWR_HIGH) && !seen && !wd_fall && outs.rst_n;
  end
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      WAKE_OUT <= 1'b0;
      RESET_N_OUT <= 1'b0;
    end else begin
      WAKE_OUT <= outs.wake;
      RESET_N_OUT <= outs.rst_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int RESP = `WWR_RESP_CYC;
  property p_wake_in_reset;
    @(posedge REF_CLK_IN) disable iff (!rst_n) !RESET_N_OUT |-> !WAKE_OUT;
  endproperty
  a_wake_in_reset: assert property (p_wake_in_reset) else $error("wake high in reset");
  property p_wd_response;
    @(posedge REF_CLK_IN) disable iff (!rst_n) $fell(wd_level) |-> ##[1:RESP] !WAKE_OUT;
  endproperty
  a_wd_response: assert property (p_wd_response) else $error("wake slow to drop");
  property p_pg_reset;
    @(posedge REF_CLK_IN) disable iff (!rst_n) !pg_level |=> !RESET_N_OUT;
  endproperty
  a_pg_reset: assert property (p_pg_reset) else $error("reset not held on low supply");
  property p_stay_low;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (state == WWR_HIGH && seen) |=> !WAKE_OUT;
  endproperty
  a_stay_low: assert property (p_stay_low) else $error("wake rose again in cycle");
  property p_miss_reset;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (state == WWR_LOW && !seen && !wd_fall && reached(cnt, half) && pg_level)
      |=> ##1 !RESET_N_OUT;
  endproperty
  a_miss_reset: assert property (p_miss_reset) else $error("no reset on missed edge");
  property p_release;
    @(posedge REF_CLK_IN) disable iff (!rst_n) $rose(RESET_N_OUT) |-> !WAKE_OUT [*2];
  endproperty
  a_release: assert property (p_release) else $error("wake rose at reset release");
  property p_brownout;
    @(posedge REF_CLK_IN) disable iff (!rst_n) $fell(pg_level) |=> !RESET_N_OUT [*2];
  endproperty
  a_brownout: assert property (p_brownout) else $error("reset not asserted on brownout");
  property p_rise_only_high;
    @(posedge REF_CLK_IN) disable iff (!rst_n) $rose(WAKE_OUT) |-> $past(state == WWR_HIGH);
  endproperty
  a_rise_only_high: assert property (p_rise_only_high) else $error("wake rose off phase");
  c_wake: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n) $rose(WAKE_OUT));
  c_wd: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n) wd_fall && WAKE_OUT);
  c_miss: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    $fell(RESET_N_OUT) && pg_level);
  c_brownout: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n) $fell(pg_level));
  c_release: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n) $rose(RESET_N_OUT));
  // wake held low through release delay
  property p_delay_quiet;
    @(posedge REF_CLK_IN) disable iff (!rst_n) (state == WWR_DELAY) |=> !WAKE_OUT;
  endproperty
  a_delay_quiet: assert property (p_delay_quiet) else $error("wake high in delay");
  property p_release_pg;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      $rose(RESET_N_OUT) |-> $past(pg_level) && $past(pg_level, 2);
  endproperty
  a_release_pg: assert property (p_release_pg) else $error("reset up on low supply");
  // high run length; a counter, since the phase is far too long to repeat
  logic [`WWR_CNT_W-1:0] high_run;
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      high_run <= '0;
    end else if (WAKE_OUT) begin
      high_run <= high_run + 1'b1;
    end else begin
      high_run <= '0;
    end
  end
  property p_high_run;
    @(posedge REF_CLK_IN) disable iff (!rst_n) WAKE_OUT |-> (high_run < half);
  endproperty
  a_high_run: assert property (p_high_run) else $error("wake high too long");
endmodule // wwr_top

// [wwr_mcu.sv]
// processor model answering the rouse wave with watchdog pulses
`timescale 1ns/1ps
module wwr_mcu (
  input wire logic clk_in, // bench clock
  input wire logic wake_in, // rouse wave
  input wire logic [1:0] mode_in, // pulses per cycle, 0 = hung
  output logic wdog_out // watchdog pin
);
  // pulse count latched at the rise, so a mid-cycle mode change waits a cycle
  int pulses;
  initial begin
    wdog_out = 1'b1;
    forever begin
      @(posedge wake_in);
      pulses = mode_in;
      repeat (10) @(negedge clk_in);
      for (int i = 0; i < pulses; i++) begin
        wdog_out = 1'b0;
        repeat (50) @(negedge clk_in);
        wdog_out = 1'b1;
        repeat (50) @(negedge clk_in);
      end
    end
  end
endmodule // wwr_mcu

// [testbench.sv]
// self-checking bench for the rouse, watchdog and reset logic
`timescale 1ns/1ps
`include "wwr_defs.svh"
module testbench;
  logic clk = 1'b0, nrst = 1'b0, pg = 1'b0, wdog, wake, rst_n;
  logic [15:0] unit = 16'h001e;
  logic [1:0] mode = 2'h1;
  int num_errors = 0, n_compared = 0, cyc = 0, u, n, m;
  // 10 mhz clock
  always #50 clk = ~clk;
  wwr_top wwr_top_inst (.REF_CLK_IN(clk), .NRST_IN(nrst), .POWER_GOOD_IN(pg),
    .WATCHDOG_INPUT_IN(wdog), .UNIT_IN(unit), .WAKE_OUT(wake), .RESET_N_OUT(rst_n));
  wwr_mcu wwr_mcu_inst (.clk_in(clk), .wake_in(wake), .mode_in(mode), .wdog_out(wdog));
  ////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // cycles until an output shows a level, bounded
  task automatic wt(input bit w, input logic v, output int c);
    c = 0;
    while ((w ? rst_n : wake) !== v && c < 2000) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, run needs under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  ////////////////////
  initial begin
    void'($urandom(32'ha571));
    u = 30 + $urandom % 11;
    unit = u[15:0];
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (60) @(negedge clk);
    chk("rst_pu", 0, rst_n);
    pg = 1'b1;
    wt(1, 1'b1, n);
    chk("pu_rel", 1, n >= u && n <= u + 8);
    wt(0, 1'b1, n);
    chk("dly", 4 * u, n);
    // one-pulse cycle, then two-pulse cycle, then hung
    for (int k = 2; k >= 0; k -= 2) begin
      wt(0, 1'b0, n);
      chk("resp", 1, n > 9 && n <= 9 + `WWR_RESP_CYC);
      mode = k[1:0];
      wt(0, 1'b1, m);
      chk("period", 8 * u, n + m);
      chk("rst_ok", 1, rst_n);
    end
    wt(0, 1'b0, n);
    chk("duty", 4 * u, n);
    wt(1, 1'b0, m);
    chk("miss", 4 * u, m);
    chk("wake_rst", 0, wake);
    mode = 2'h1;
    wt(1, 1'b1, n);
    chk("rst_w", u, n);
    wt(0, 1'b1, n);
    chk("dly2", 4 * u, n);
    // brownout in the high half
    repeat (5) @(negedge clk);
    pg = 1'b0;
    wt(1, 1'b0, n);
    chk("bo", 1, n <= 20);
    @(negedge clk);
    chk("wake_bo", 0, wake);
    repeat (20 + $urandom % 80) @(negedge clk);
    chk("bo_hold", 0, rst_n);
    pg = 1'b1;
    wt(1, 1'b1, n);
    chk("bo_rel", 1, n >= u && n <= u + 8);
    wt(0, 1'b1, n);
    chk("dly3", 4 * u, n);
    end_of_test;
  end
endmodule // testbench
